//--- rtl/lamp_pkg.sv
package lamp_pkg;
  // ==========================================================
  // host i/o port addresses and unlock keys
  localparam logic [15:0] CFG_INDEX_PORT = 16'h0302;
  localparam logic [15:0] CFG_DATA_PORT = 16'h0303;
  localparam logic [7:0] KEY_FIRST = 8'h46;
  localparam logic [7:0] KEY_SECOND = 8'h57;
  // ==========================================================
  // configuration indices
  localparam logic [7:0] IDX_DEVICE_SELECT = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_BASE_LOW = 8'h61;
  localparam logic [7:0] LAMP_DEVICE_NUMBER = 8'h05;
  localparam logic [15:0] STATE_OFFSET = 16'h0000;
  // ==========================================================
  // reset values
  localparam logic [7:0] ACTIVATE_RESET = 8'h00;
  localparam logic [3:0] STATE_RESET = 4'h1;
  localparam logic [7:0] BASE_HIGH_RESET = 8'h00;
  localparam logic [7:0] BASE_LOW_RESET = 8'h00;
  localparam logic [7:0] DEVICE_RESET = 8'h00;
  // ==========================================================
  // blink timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned FAST_BLINK_HZ = 8;
  localparam int unsigned SLOW_BLINK_HZ = 1;
  // half period in cycles, so one full blink is two toggles
  localparam int unsigned FAST_HALF_CYCLES = CLK_HZ / (2 * FAST_BLINK_HZ);
  localparam int unsigned SLOW_HALF_CYCLES = CLK_HZ / (2 * SLOW_BLINK_HZ);
  // ==========================================================
  // per-element state codes
  typedef enum logic [1:0] {
    LAMP_OFF = 2'b00,
    LAMP_FAST = 2'b01,
    LAMP_SLOW = 2'b10,
    LAMP_ON = 2'b11
  } lamp_code_t;
endpackage : lamp_pkg

//--- rtl/blink_if.sv
`timescale 1ns/10ps
// carries the shared blink phases to each element driver
interface blink_if;
  logic fast_phase;
  logic slow_phase;
  modport source (output fast_phase, output slow_phase);
  modport sink (input fast_phase, input slow_phase);
endinterface : blink_if

//--- rtl/lamp_element.sv
`timescale 1ns/10ps
// one colour element: decodes its two-bit code into a lamp level
module lamp_element (
  input wire logic ref_clk_i,          // board clock
  input wire logic srst_i,             // sync reset, active high
  input wire logic enable_i,           // activation bit
  input wire logic [1:0] code_i,       // state code
  blink_if.sink phase,                 // shared blink phases
  output logic lamp_o                  // element drive, high lights it
);
  typedef struct packed {
    logic lamp;
  } elem_state_t;

  elem_state_t st_q;
  elem_state_t st_d;

  // decode code into a level, off while inactive
  always_comb begin
    st_d = st_q;
    unique case (lamp_pkg::lamp_code_t'(code_i))
      lamp_pkg::LAMP_OFF: st_d.lamp = 1'b0; // RULE8
      lamp_pkg::LAMP_FAST: st_d.lamp = phase.fast_phase; // RULE9
      lamp_pkg::LAMP_SLOW: st_d.lamp = phase.slow_phase; // RULE10
      lamp_pkg::LAMP_ON: st_d.lamp = 1'b1; // RULE8
    endcase
    if (!enable_i) begin
      st_d.lamp = 1'b0; // RULE13
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lamp_o = st_q.lamp;
endmodule : lamp_element

//--- rtl/indicator_lamp_config_ctrl.sv
`timescale 1ns/10ps
// How it works
// RULE1 - writing 46h then 57h to index port 302h unlocks configuration
// RULE2 - writing 57h then 46h to index port relocks; config registers then ignore accesses
// RULE3 - index 7 selects logical device via data port 303h; lamp is device 5
// RULE4 - activation register at index 30h resets 00h; bit 0 enables the lamp
// RULE5 - 16-bit i/o base: high byte index 60h, low byte 61h, read/write
// RULE6 - state register at base+0 resets 01h; bits 3:0 stored, 7:4 read zero
// RULE7 - bits 1:0 drive green, bits 3:2 drive red, independently coded
// RULE8 - code 00 turns element off, code 11 keeps it lit
// RULE9 - code 01 blinks element at 8 Hz
// RULE10 - code 10 blinks element at 1 Hz
// RULE11 - red and green driven independently; both lit gives orange
// RULE12 - software programs base and activation before using the state register
// RULE13 - blink from free-running dividers, 50 percent duty; both off when inactive
module indicator_lamp_config_ctrl #(
  parameter int unsigned FAST_HALF = lamp_pkg::FAST_HALF_CYCLES, // cycles per 8 Hz half period
  parameter int unsigned SLOW_HALF = lamp_pkg::SLOW_HALF_CYCLES  // cycles per 1 Hz half period
) (
  input wire logic ref_clk_i,          // board clock, 125 MHz
  input wire logic srst_i,             // sync reset, active high
  input wire logic [15:0] io_addr_i,   // host i/o address
  input wire logic [7:0] io_wdata_i,   // host write byte
  input wire logic io_wr_i,            // one-cycle write strobe
  input wire logic io_rd_i,            // one-cycle read strobe
  output logic [7:0] io_rdata_o,       // read byte, registered
  output logic io_rvalid_o,            // read data valid pulse
  output logic green_lamp_o,           // green element drive
  output logic red_lamp_o              // red element drive
);
  localparam int unsigned CNT_W = 27;

  // counters must fit and never be zero; refused while elaborating
  if (FAST_HALF < 1 || SLOW_HALF < 1 || FAST_HALF >= (1 << CNT_W) ||
      SLOW_HALF >= (1 << CNT_W)) begin : g_bad_half
    $error("blink half periods out of range");
  end

  localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(FAST_HALF - 1);
  localparam logic [CNT_W-1:0] SLOW_LAST = CNT_W'(SLOW_HALF - 1);

  // ==========================================================
  // state
  typedef struct packed {
    logic key_armed;        // first unlock key seen last write
    logic lock_armed;       // first lock key seen last write
    logic unlocked;
    logic [7:0] index;
    logic [7:0] device;
    logic [7:0] activate;
    logic [7:0] base_high;
    logic [7:0] base_low;
    logic [3:0] lamp_state;
    logic [CNT_W-1:0] fast_cnt;
    logic [CNT_W-1:0] slow_cnt;
    logic fast_phase;
    logic slow_phase;
    logic [7:0] rdata;
    logic rvalid;
  } ctrl_state_t;

  ctrl_state_t st_q;
  ctrl_state_t st_d;

  logic idx_hit;
  logic dat_hit;
  logic lamp_sel;
  logic state_hit;
  logic [15:0] base_addr;

  // ==========================================================
  // address decode
  assign base_addr = {st_q.base_high, st_q.base_low}; // RULE5
  assign idx_hit = (io_addr_i == lamp_pkg::CFG_INDEX_PORT);
  // data port only answers while unlocked
  assign dat_hit = (io_addr_i == lamp_pkg::CFG_DATA_PORT) && st_q.unlocked; // RULE2
  assign lamp_sel = (st_q.device == lamp_pkg::LAMP_DEVICE_NUMBER); // RULE3
  // state register lives in i/o space only while activated
  assign state_hit = st_q.activate[0] &&
                     (io_addr_i == base_addr + lamp_pkg::STATE_OFFSET); // RULE4 RULE6

  // ==========================================================
  // next-state logic
  always_comb begin
    st_d = st_q;
    st_d.rvalid = 1'b0;

    // free-running dividers, toggling each half period
    if (st_q.fast_cnt == FAST_LAST) begin
      st_d.fast_cnt = '0;
      st_d.fast_phase = ~st_q.fast_phase; // RULE13
    end else begin
      st_d.fast_cnt = st_q.fast_cnt + CNT_W'(1);
    end
    if (st_q.slow_cnt == SLOW_LAST) begin
      st_d.slow_cnt = '0;
      st_d.slow_phase = ~st_q.slow_phase; // RULE13
    end else begin
      st_d.slow_cnt = st_q.slow_cnt + CNT_W'(1);
    end

    // index port: key sequence tracking and index latch
    if (io_wr_i && idx_hit) begin
      // any other write between keys breaks the pair
      st_d.key_armed = (io_wdata_i == lamp_pkg::KEY_FIRST);
      st_d.lock_armed = st_q.unlocked && (io_wdata_i == lamp_pkg::KEY_SECOND);
      if (!st_q.unlocked && st_q.key_armed && io_wdata_i == lamp_pkg::KEY_SECOND) begin
        st_d.unlocked = 1'b1; // RULE1
        st_d.key_armed = 1'b0;
      end
      if (st_q.unlocked && st_q.lock_armed && io_wdata_i == lamp_pkg::KEY_FIRST) begin
        st_d.unlocked = 1'b0; // RULE2
        st_d.key_armed = 1'b0;
      end
      if (st_q.unlocked) begin
        st_d.index = io_wdata_i;
      end
    end else if (io_wr_i) begin
      // another port write between keys breaks the sequence
      st_d.key_armed = 1'b0;
      st_d.lock_armed = 1'b0;
    end

    // data port writes
    if (io_wr_i && dat_hit) begin
      if (st_q.index == lamp_pkg::IDX_DEVICE_SELECT) begin
        st_d.device = io_wdata_i; // RULE3
      end else if (lamp_sel) begin
        unique case (st_q.index)
          lamp_pkg::IDX_ACTIVATE: st_d.activate = io_wdata_i; // RULE4
          lamp_pkg::IDX_BASE_HIGH: st_d.base_high = io_wdata_i; // RULE5
          lamp_pkg::IDX_BASE_LOW: st_d.base_low = io_wdata_i; // RULE5
          default: ;
        endcase
      end
    end

    // lamp state register write, upper nibble dropped
    if (io_wr_i && state_hit && !idx_hit && !dat_hit) begin
      st_d.lamp_state = io_wdata_i[3:0]; // RULE6
    end

    // reads: config port first, then the state register
    if (io_rd_i) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = 8'h00;
      if (idx_hit && st_q.unlocked) begin
        st_d.rdata = st_q.index;
      end else if (dat_hit) begin
        if (st_q.index == lamp_pkg::IDX_DEVICE_SELECT) begin
          st_d.rdata = st_q.device;
        end else if (lamp_sel) begin
          unique case (st_q.index)
            lamp_pkg::IDX_ACTIVATE: st_d.rdata = st_q.activate;
            lamp_pkg::IDX_BASE_HIGH: st_d.rdata = st_q.base_high;
            lamp_pkg::IDX_BASE_LOW: st_d.rdata = st_q.base_low;
            default: st_d.rdata = 8'h00;
          endcase
        end
      end else if (state_hit) begin
        st_d.rdata = {4'h0, st_q.lamp_state}; // RULE6
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_q <= '0;
      st_q.index <= 8'h00;
      st_q.device <= lamp_pkg::DEVICE_RESET;
      st_q.activate <= lamp_pkg::ACTIVATE_RESET; // RULE4
      st_q.base_high <= lamp_pkg::BASE_HIGH_RESET;
      st_q.base_low <= lamp_pkg::BASE_LOW_RESET;
      st_q.lamp_state <= lamp_pkg::STATE_RESET; // RULE6
    end else begin
      st_q <= st_d;
    end
  end

  assign io_rdata_o = st_q.rdata;
  assign io_rvalid_o = st_q.rvalid;

  // ==========================================================
  // element drivers share one pair of dividers
  blink_if phases ();
  assign phases.fast_phase = st_q.fast_phase;
  assign phases.slow_phase = st_q.slow_phase;

  // green from bits 1:0, red from bits 3:2, no coupling between them
  lamp_element green_elem (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .enable_i(st_q.activate[0]),
    .code_i(st_q.lamp_state[1:0]), // RULE7
    .phase(phases),
    .lamp_o(green_lamp_o)
  );

  lamp_element red_elem (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .enable_i(st_q.activate[0]),
    .code_i(st_q.lamp_state[3:2]), // RULE7 RULE11
    .phase(phases),
    .lamp_o(red_lamp_o)
  );
endmodule : indicator_lamp_config_ctrl

//--- bench/lamp_checker.sv
`timescale 1ns/10ps
// ======================================================
// port checker for the indicator lamp controller
module lamp_checker #(
  parameter int unsigned FAST_HALF = 4, // fast half period
  parameter int unsigned SLOW_HALF = 32 // slow half period
) (
  input wire logic ref_clk_i, // board clock
  input wire logic srst_i, // sync reset
  input wire logic [15:0] io_addr_i, // host address
  input wire logic [7:0] io_wdata_i, // write byte
  input wire logic io_wr_i, // write strobe
  input wire logic io_rd_i, // read strobe
  input wire logic [7:0] io_rdata_o, // read byte
  input wire logic io_rvalid_o, // read valid
  input wire logic green_lamp_o, // green drive
  input wire logic red_lamp_o // red drive
);
  logic unl_q, k46_q, k57_q, wi, wd, ws, cfg, act0, on_g, off_r;
  logic [7:0] idx_q, dev_q, act_q, bh_q, bl_q;
  logic [3:0] st_q;
  // decodes of the current strobe against the shadow state
  assign wi = io_wr_i && io_addr_i == 16'h0302;
  assign wd = io_wr_i && io_addr_i == 16'h0303;
  assign ws = io_wr_i && act0 && io_addr_i == {bh_q, bl_q};
  assign cfg = unl_q && dev_q == 8'h05;
  assign act0 = act_q[0];
  assign on_g = act0 && st_q[1:0] == 2'b11;
  assign off_r = act0 && st_q[3:2] == 2'b00;
  // shadow register file; key detection only looks at io writes
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      {unl_q, k46_q, k57_q, idx_q, dev_q, act_q, bh_q, bl_q} <= '0;
      st_q <= 4'h1;
    end else if (io_wr_i) begin
      k46_q <= wi && io_wdata_i == 8'h46;
      k57_q <= wi && io_wdata_i == 8'h57;
      if (wi && !unl_q && k46_q && io_wdata_i == 8'h57) unl_q <= 1'b1;
      if (wi && unl_q && k57_q && io_wdata_i == 8'h46) unl_q <= 1'b0;
      if (wi && unl_q) idx_q <= io_wdata_i;
      if (wd && unl_q && idx_q == 8'h07) dev_q <= io_wdata_i;
      if (wd && cfg && idx_q == 8'h30) act_q <= io_wdata_i;
      if (wd && cfg && idx_q == 8'h60) bh_q <= io_wdata_i;
      if (wd && cfg && idx_q == 8'h61) bl_q <= io_wdata_i;
      if (ws) st_q <= io_wdata_i[3:0];
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_state_rd;
    io_rd_i && act0 && io_addr_i == {bh_q, bl_q};
  endsequence
  // ======================================================
  // assertions
  a_read_answer: assert property (io_rd_i |=> io_rvalid_o)
    else $error("read not answered");
  a_answer_cause: assert property (io_rvalid_o |-> $past(io_rd_i))
    else $error("stray read valid");
  a_rdata_holds: assert property (!io_rvalid_o |-> $stable(io_rdata_o))
    else $error("read data moved");
  a_locked_read: assert property (io_rd_i && !unl_q && io_addr_i[15:1] == 15'h0181
    |=> io_rdata_o == 8'h00) else $error("locked port answered");
  a_index_read: assert property (io_rd_i && unl_q && io_addr_i == 16'h0302
    |=> io_rdata_o == $past(idx_q)) else $error("index readback wrong");
  a_device_read: assert property (wd == 1'b0 && io_rd_i && unl_q && io_addr_i == 16'h0303 && idx_q == 8'h07
    |=> io_rdata_o == $past(dev_q)) else $error("device readback wrong");
  a_base_read: assert property (io_rd_i && cfg && io_addr_i == 16'h0303 && idx_q == 8'h60
    |=> io_rdata_o == $past(bh_q)) else $error("base readback wrong");
  a_state_read: assert property (s_state_rd |=> io_rdata_o == {4'h0, $past(st_q)})
    else $error("state readback wrong");
  a_dark_inactive: assert property (!$past(act0) |-> !green_lamp_o && !red_lamp_o)
    else $error("lamp lit while inactive");
  a_steady_on: assert property ($past(on_g) |-> green_lamp_o)
    else $error("steady green not lit");
  a_red_off: assert property ($past(off_r) |-> !red_lamp_o)
    else $error("red lit with code off");
endmodule : lamp_checker
bind indicator_lamp_config_ctrl lamp_checker #(.FAST_HALF(FAST_HALF), .SLOW_HALF(SLOW_HALF)) chk (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
  .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o),
  .green_lamp_o(green_lamp_o), .red_lamp_o(red_lamp_o));

//--- bench/indicator_lamp_config_ctrl_tb.sv
`timescale 1ns/10ps
module indicator_lamp_config_ctrl_tb;
  typedef struct {logic [7:0] wr_b; logic [7:0] rd_b; logic grn; logic red;} row_t;
  logic ref_clk_i = 1'b0, srst_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0;
  logic [15:0] io_addr_i = 16'h0000;
  logic [7:0] io_wdata_i = 8'h00, io_rdata_o;
  logic io_rvalid_o, green_lamp_o, red_lamp_o;
  int err_count = 0, total_checks = 0;
  // steady codes only; high nibble written to prove it reads back zero
  row_t rows[4] = '{'{8'h00, 8'h00, 1'b0, 1'b0}, '{8'hf3, 8'h03, 1'b1, 1'b0},
    '{8'h0c, 8'h0c, 1'b0, 1'b1}, '{8'h5f, 8'h0f, 1'b1, 1'b1}};
  // short blink halves keep the rate check inside a few hundred cycles
  indicator_lamp_config_ctrl #(.FAST_HALF(4), .SLOW_HALF(32)) uut (.ref_clk_i(ref_clk_i),
    .srst_i(srst_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o),
    .green_lamp_o(green_lamp_o), .red_lamp_o(red_lamp_o));
  // 125 MHz board clock
  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // ======================================================
  // bus tasks, idle cycle between strobes
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic put_b(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(negedge ref_clk_i);
    io_wr_i = 1'b0;
  endtask : put_b
  task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
    put_b(16'h0302, idx);
    put_b(16'h0303, d);
  endtask : cfg
  task automatic get_b(input logic [15:0] a, input logic [7:0] exp);
    @(negedge ref_clk_i);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge ref_clk_i);
    io_rd_i = 1'b0;
    check("rvalid", {7'h00, io_rvalid_o}, 8'h01);
    check("rdata", io_rdata_o, exp);
  endtask : get_b
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  // watchdog, about thirteen times the expected run
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    err_count++;
    end_sim();
  end
  // ======================================================
  // main sequence
  initial begin
    int g;
    int r;
    logic pg;
    logic pr;
    repeat (2) @(negedge ref_clk_i);
    srst_i = 1'b0;
    get_b(16'h0303, 8'h00);
    put_b(16'h0302, 8'h46);
    put_b(16'h0302, 8'h00);
    put_b(16'h0302, 8'h57);
    get_b(16'h0302, 8'h00);
    put_b(16'h0302, 8'h46);
    put_b(16'h0302, 8'h57);
    cfg(8'h07, 8'h06);
    cfg(8'h30, 8'h01);
    cfg(8'h07, 8'h05);
    get_b(16'h0303, 8'h05);
    put_b(16'h0302, 8'h30);
    get_b(16'h0303, 8'h00);
    cfg(8'h60, 8'h03);
    cfg(8'h61, 8'h1d);
    get_b(16'h0303, 8'h1d);
    put_b(16'h0302, 8'h60);
    get_b(16'h0303, 8'h03);
    get_b(16'h0302, 8'h60);
    cfg(8'h30, 8'h01);
    get_b(16'h031d, 8'h01);
    // steady codes through the table
    foreach (rows[i]) begin
      put_b(16'h031d, rows[i].wr_b);
      get_b(16'h031d, rows[i].rd_b);
      repeat (2) @(negedge ref_clk_i);
      check("green", {7'h00, green_lamp_o}, {7'h00, rows[i].grn});
      check("red", {7'h00, red_lamp_o}, {7'h00, rows[i].red});
    end
    // green fast, red slow: count rising edges over 256 cycles, four slow periods of 64
    put_b(16'h031d, 8'h09);
    repeat (4) @(negedge ref_clk_i);
    g = 0;
    r = 0;
    repeat (256) begin
      pg = green_lamp_o;
      pr = red_lamp_o;
      @(negedge ref_clk_i);
      if (!pg && green_lamp_o) g++;
      if (!pr && red_lamp_o) r++;
    end
    check("fast rises", 8'(g), 8'h20);
    check("slow rises", 8'(r), 8'h04);
    cfg(8'h30, 8'h00);
    get_b(16'h031d, 8'h00);
    check("dark", {6'h00, green_lamp_o, red_lamp_o}, 8'h00);
    put_b(16'h0302, 8'h57);
    put_b(16'h0302, 8'h46);
    get_b(16'h0302, 8'h00);
    // reset in mid run returns to the locked state
    put_b(16'h0302, 8'h46);
    put_b(16'h0302, 8'h57);
    // light both elements so the reset has something to clear
    cfg(8'h30, 8'h01);
    put_b(16'h031d, 8'h0f);
    repeat (2) @(negedge ref_clk_i);
    check("lit before reset", {6'h00, green_lamp_o, red_lamp_o}, 8'h03);
    srst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    srst_i = 1'b0;
    check("reset lamps", {6'h00, green_lamp_o, red_lamp_o}, 8'h00);
    get_b(16'h0302, 8'h00);
    get_b(16'h0000, 8'h00);
    end_sim();
  end
endmodule : indicator_lamp_config_ctrl_tb
